// ---- bench/sli_far_model.sv ----
// Far side of the lamp block: supply wiring of the channel inputs and lamp observer.
// Assumes the bench selects one lamp to watch and clears the counters between windows.
`timescale 1ns/1ps
module sli_far_model
	import sli_pkg::*;
(
	input wire logic clk,
	input wire sli_lamps_s lamps,
	input wire logic [1:0] lamp_sel,
	input wire logic cnt_clr,
	input wire logic [1:0] wiring,
	output logic channel_select_supply_a,
	output logic channel_select_supply_b,
	output logic [15:0] on_cnt,
	output logic [15:0] rise_cnt
);
	logic prev_r;

	////////////////////////////////////////////////////////////////
	// Installer wiring: opposite polarity, code 2 is a miswired pair at 0 V
	assign channel_select_supply_a = (wiring == 2'h0);
	assign channel_select_supply_b = (wiring == 2'h1);

	////////////////////////////////////////////////////////////////
	// Count lit cycles and switch-on edges; an unknown lamp counts as dark
	always @(posedge clk) begin
		if (cnt_clr) begin
			on_cnt <= 16'h0;
			rise_cnt <= 16'h0;
		end else begin
			if (lamps[lamp_sel] === 1'b1)
				on_cnt <= on_cnt + 16'h1;
			if (lamps[lamp_sel] === 1'b1 && prev_r !== 1'b1)
				rise_cnt <= rise_cnt + 16'h1;
		end
		prev_r <= lamps[lamp_sel];
	end
endmodule

// ---- bench/tb.sv ----
// Self-checking bench of the status lamp block: lamp patterns, channel decode,
// registers and interrupt. Assumes a short flash tick of 10 cycles.
`timescale 1ns/1ps
module tb;
	import sli_pkg::*;
	localparam sli_status_s S0 = '0;
	localparam sli_status_s S_ON = '{outputs_on: 1'b1, default: 1'b0};
	localparam sli_status_s S_WEAK = '{weak_signal: 1'b1, default: 1'b0};
	localparam sli_status_s S_INT = '{internal_fault: 1'b1, default: 1'b0};
	localparam sli_status_s S_EXT = '{external_fault: 1'b1, default: 1'b0};
	localparam sli_status_s S_IL = '{interlock_enabled: 1'b1, default: 1'b0};
	localparam sli_status_s S_BLK = '{interlock_blocking: 1'b1, default: 1'b0};
	localparam sli_status_s S_FREE = '{field_clear: 1'b1, linked_ok: 1'b1, default: 1'b0};
	localparam sli_status_s S_UPO = '{upstream_open: 1'b1, default: 1'b0};
	localparam sli_status_s S_CHG = '{upstream_change: 1'b1, default: 1'b0};
	localparam sli_status_s S_TW = '{upstream_twice: 1'b1, default: 1'b0};
	localparam sli_status_s S_BLNK = '{blank_taught: 1'b1, default: 1'b0};
	localparam sli_status_s S_MUTE = '{muting_active: 1'b1, default: 1'b0};
	localparam sli_status_s S_TREQ = '{teach_required: 1'b1, default: 1'b0};
	localparam sli_status_s S_MRST = '{muting_restart: 1'b1, default: 1'b0};
	localparam sli_status_s S_OVR = '{muting_override: 1'b1, default: 1'b0};
	localparam sli_status_s S_TF = '{teach_failed: 1'b1, default: 1'b0};
	// Lamp bit index and pattern codes: dark, steady, fast, slow, short, any flash
	localparam logic [1:0] RED = 2'h3, GRN = 2'h2, YEL = 2'h1, BLU = 2'h0;
	localparam int DARK = 0, STDY = 1, FAST = 2, SLOW = 3, SHRT = 4, FLSH = 5;
	logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, cnt_clr = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic [1:0] lamp_sel = 2'h0, wiring = 2'h0;
	sli_status_s status = '0;
	sli_lamps_s lamps;
	logic sa, sb, ch1, ch2, irq, avs_waitrequest;
	logic [15:0] on_cnt, rise_cnt;
	int bad_count = 0, n_compared = 0;

	////////////////////////////////////////////////////////////////
	// Clock, watchdog and instances; a short tick keeps each pattern window at 400 cycles
	always #12.5 clk = ~clk;
	initial begin
		#(25 * 30000);
		bad_count++;
		final_report();
	end
	sli_status_led #(.FAST_HALF_CYC(24'h00000a)) DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
		.status(status), .channel_select_supply_a(sa), .channel_select_supply_b(sb), .lamps(lamps),
		.light_channel_one(ch1), .light_channel_two(ch2), .irq(irq), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	sli_far_model far (.clk(clk), .lamps(lamps), .lamp_sel(lamp_sel), .cnt_clr(cnt_clr), .wiring(wiring),
		.channel_select_supply_a(sa), .channel_select_supply_b(sb), .on_cnt(on_cnt), .rise_cnt(rise_cnt));

	////////////////////////////////////////////////////////////////
	// Reporting
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		if (bad_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Avalon-MM master: hold the request until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do @(negedge clk); while (avs_waitrequest !== 1'b0);
		@(posedge clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		cmp(q & mask, exp);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	////////////////////////////////////////////////////////////////
	// Lamp pattern check: apply state, settle, watch one lamp for two seconds of ticks
	task automatic pat(input sli_status_s s, input logic [1:0] sel, input int exp);
		int p;
		@(posedge clk);
		status <= s;
		lamp_sel <= sel;
		repeat (4) @(posedge clk);
		cnt_clr <= 1'b1;
		@(posedge clk);
		cnt_clr <= 1'b0;
		repeat (400) @(posedge clk);
		@(negedge clk);
		p = (on_cnt == 0) ? DARK : (on_cnt > 390) ? STDY : (rise_cnt > 14) ? FAST : (on_cnt > 100) ? SLOW : SHRT;
		if (exp == FLSH && (p == FAST || p == SLOW))
			p = FLSH;
		cmp(p, exp);
	endtask
	// Upstream changeover burst counted on lamp two from dark
	task automatic burst(input sli_status_s base, input int exp);
		pat(base, YEL, DARK);
		@(posedge clk);
		cnt_clr <= 1'b1;
		@(posedge clk);
		cnt_clr <= 1'b0;
		status <= base | S_CHG;
		@(posedge clk);
		status <= base;
		repeat (80) @(posedge clk);
		@(negedge clk);
		cmp(32'(rise_cnt), exp);
	endtask
	task automatic chan(input logic [1:0] w, input logic [1:0] exp);
		wiring <= w;
		repeat (8) @(posedge clk);
		@(negedge clk);
		cmp(32'({ch2, ch1}), 32'(exp));
		rd(SLI_OFS_STATE, 32'h3, 32'(exp));
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rd(SLI_OFS_CTRL, 32'h1, 32'h1);
		rd(SLI_OFS_IRQ_EN, 32'h1f, 32'h0);
		rd(5'h14, 32'hffffffff, 32'h0);
		chan(2'h0, 2'h1);
		chan(2'h1, 2'h2);
		chan(2'h2, 2'h0);
		wr(SLI_OFS_IRQ_CLR, 32'h1f);
		wr(SLI_OFS_IRQ_EN, 32'h1);
		rd(SLI_OFS_IRQ_STAT, 32'h1f, 32'h0);
		pat(S0, RED, STDY);
		pat(S_ON, GRN, STDY);
		pat(S_ON | S_WEAK, GRN, SLOW);
		pat(S_INT | S_ON, RED, FAST);
		cmp(32'(irq), 32'h1);
		rd(SLI_OFS_IRQ_STAT, 32'h1, 32'h1);
		wr(SLI_OFS_IRQ_CLR, 32'h1);
		@(negedge clk);
		cmp(32'(irq), 32'h0);
		pat(S_INT | S_ON, GRN, DARK);
		pat(S_EXT, RED, SLOW);
		cmp(32'(irq), 32'h0);
		rd(SLI_OFS_IRQ_STAT, 32'h3, 32'h2);
		pat(S0, YEL, DARK);
		pat(S_IL, YEL, DARK);
		pat(S_IL | S_BLK, YEL, DARK);
		pat(S_IL | S_BLK | S_FREE, YEL, STDY);
		pat(S_UPO, YEL, FLSH);
		burst(S0, 1);
		burst(S_TW, 2);
		pat(S_ON, BLU, DARK);
		pat(S_BLNK, BLU, STDY);
		pat(S_MUTE, BLU, SLOW);
		pat(S_TREQ, BLU, SHRT);
		pat(S_MRST, BLU, SHRT);
		pat(S_OVR | S_MUTE, BLU, SHRT);
		pat(S_TF, BLU, FAST);
		pat(S_TF | S_MUTE | S_BLNK, BLU, FAST);
		wr(SLI_OFS_CTRL, 32'h0);
		pat(S0, RED, DARK);
		wr(SLI_OFS_CTRL, 32'h1);
		pat(S0, RED, STDY);
		final_report();
	end
endmodule

// ---- design/sli_status_led.sv ----
// Status lamp indicator: three lamps, flash generation, channel decode,
// Avalon-MM register slave and a level interrupt.
// Assumes status inputs come from logic on clk; supply-level channel
// inputs are asynchronous pins.
//
// Summary of operation
// - Lamp one red when outputs off, green when on, green 1 Hz on weak signal.
// - Lamp one flashes red 10 Hz for internal fault, 1 Hz for external.
// - Lamp two dark if interlock off, released, or blocking with field interrupted.
// - Lamp two steady yellow when interlock blocking, field clear, linked sensor ok.
// - Lamp two flashes yellow while the upstream safety circuit is open.
// - Upstream changeover gives a short burst of one or two yellow flashes.
// - Lamp three dark when no special function is active.
// - Lamp three steady blue when blanking taught, blue 1 Hz while muting.
// - Short blue flashes for teach required, muting restart or muting override.
// - Lamp three flashes blue 10 Hz when teaching failed.
// - Supply A high and B low selects channel one; reversed selects channel two.
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module sli_status_led
	import sli_pkg::*;
#(
	parameter logic [23:0] FAST_HALF_CYC = SLI_FAST_HALF_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire sli_status_s status,
	input wire logic channel_select_supply_a,
	input wire logic channel_select_supply_b,
	output sli_lamps_s lamps,
	output logic light_channel_one,
	output logic light_channel_two,
	output logic irq,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	////////////////////////////////////////////////////////////////////////
	// Flash dividers

	logic [23:0] base_cnt_r;
	logic tick;
	logic fast_on_r;
	logic [4:0] slow_ph_r;
	logic slow_on;
	logic short_on;

	assign tick = (base_cnt_r == FAST_HALF_CYC - 24'h1);
	assign slow_on = (slow_ph_r < SLI_SLOW_ON_TICKS);
	assign short_on = (slow_ph_r == 5'h0); // One 50 ms flash per second

	// Base counter runs free; never reset by status so patterns stay steady
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			base_cnt_r <= 24'h0;
		end else if (clk_en) begin
			base_cnt_r <= tick ? 24'h0 : base_cnt_r + 24'h1;
		end
	end

	// 10 Hz square wave and 1 Hz phase
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fast_on_r <= 1'b1;
			slow_ph_r <= 5'h0;
		end else if (clk_en && tick) begin
			fast_on_r <= ~fast_on_r;
			slow_ph_r <= (slow_ph_r == SLI_SLOW_TICKS - 5'h1) ? 5'h0 : slow_ph_r + 5'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Upstream changeover burst

	sli_burst_e burst_st_r;
	logic [2:0] burst_left_r;

	// Each flash is one tick on, one tick off; a new changeover restarts it
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			burst_st_r <= SLI_IDLE;
			burst_left_r <= 3'h0;
		end else if (clk_en) begin
			if (status.upstream_change) begin
				burst_st_r <= SLI_BURST;
				burst_left_r <= status.upstream_twice ? 3'h4 : 3'h2;
			end else begin
				case (burst_st_r)
					SLI_IDLE: begin
						burst_left_r <= 3'h0;
					end
					SLI_BURST: begin
						if (tick) begin
							burst_left_r <= burst_left_r - 3'h1;
							if (burst_left_r == 3'h1) begin
								burst_st_r <= SLI_IDLE;
							end
						end
					end
					default: begin
						burst_st_r <= SLI_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Lamp pattern selection

	logic lamp_en_r;
	sli_lamps_s lamps_nxt;
	logic ready_to_release;

	assign ready_to_release = status.interlock_enabled && status.interlock_blocking
		&& status.field_clear && status.linked_ok;

	// Fixed priority per lamp: errors, then teach states, then normal status
	always_comb begin
		lamps_nxt = '0;
		if (status.internal_fault) begin
			lamps_nxt.red1 = fast_on_r;
		end else if (status.external_fault) begin
			lamps_nxt.red1 = slow_on;
		end else if (!status.outputs_on) begin
			lamps_nxt.red1 = 1'b1;
		end else if (status.weak_signal) begin
			lamps_nxt.green1 = slow_on;
		end else begin
			lamps_nxt.green1 = 1'b1;
		end
		if (burst_st_r == SLI_BURST) begin
			lamps_nxt.yellow2 = ~burst_left_r[0];
		end else if (status.upstream_open) begin
			lamps_nxt.yellow2 = slow_on;
		end else begin
			lamps_nxt.yellow2 = ready_to_release;
		end
		if (status.teach_failed) begin
			lamps_nxt.blue3 = fast_on_r;
		end else if (status.teach_required || status.muting_restart || status.muting_override) begin
			lamps_nxt.blue3 = short_on;
		end else if (status.muting_active) begin
			lamps_nxt.blue3 = slow_on;
		end else begin
			lamps_nxt.blue3 = status.blank_taught;
		end
		if (!lamp_en_r) begin
			lamps_nxt = '0;
		end
	end

	// Lamps registered so the pins never glitch between patterns
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lamps <= '0;
		end else if (clk_en) begin
			lamps <= lamps_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channel select pins

	logic [2:0] sup_a_r;
	logic [2:0] sup_b_r;
	logic chan_evt;

	// Three-stage capture; a level counts once stages two and three agree
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sup_a_r <= 3'h0;
			sup_b_r <= 3'h0;
		end else if (clk_en) begin
			sup_a_r <= {sup_a_r[1:0], channel_select_supply_a};
			sup_b_r <= {sup_b_r[1:0], channel_select_supply_b};
		end
	end

	// Equal levels are miswiring: neither channel is selected
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			light_channel_one <= 1'b0;
			light_channel_two <= 1'b0;
		end else if (clk_en && sup_a_r[1] == sup_a_r[2] && sup_b_r[1] == sup_b_r[2]) begin
			light_channel_one <= sup_a_r[2] && !sup_b_r[2];
			light_channel_two <= !sup_a_r[2] && sup_b_r[2];
		end
	end

	assign chan_evt = (sup_a_r[1] == sup_a_r[2]) && (sup_b_r[1] == sup_b_r[2])
		&& ((sup_a_r[2] && !sup_b_r[2]) != light_channel_one
		|| (!sup_a_r[2] && sup_b_r[2]) != light_channel_two);

	////////////////////////////////////////////////////////////////////////
	// Events and interrupt

	logic [2:0] prev_r;
	logic [SLI_EV_W-1:0] events;
	logic [SLI_EV_W-1:0] irq_stat_r;
	logic [SLI_EV_W-1:0] irq_en_r;
	logic wr_go;
	logic rd_go;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_r <= 3'h0;
		end else if (clk_en) begin
			prev_r <= {status.internal_fault, status.external_fault, status.teach_failed};
		end
	end

	assign events[SLI_EV_INT_FAULT] = status.internal_fault && !prev_r[2];
	assign events[SLI_EV_EXT_FAULT] = status.external_fault && !prev_r[1];
	assign events[SLI_EV_UP_CHANGE] = status.upstream_change;
	assign events[SLI_EV_TEACH_FAIL] = status.teach_failed && !prev_r[0];
	assign events[SLI_EV_CHANNEL] = chan_evt;

	// Set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_stat_r <= '0;
		end else if (clk_en) begin
			if (wr_go && avs_address == SLI_OFS_IRQ_CLR && avs_byteenable[0]) begin
				irq_stat_r <= (irq_stat_r & ~avs_writedata[SLI_EV_W-1:0]) | events;
			end else begin
				irq_stat_r <= irq_stat_r | events;
			end
		end
	end

	assign irq = |(irq_stat_r & irq_en_r);

	////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait cycle, then the answer

	logic ack_r;
	logic [31:0] rd_nxt;

	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
	assign wr_go = avs_write && ack_r;
	assign rd_go = avs_read && !ack_r;

	// Read mux; unmapped offsets and write-only registers read zero
	always_comb begin
		rd_nxt = 32'h0;
		case (avs_address)
			SLI_OFS_CTRL: rd_nxt[SLI_CTRL_LAMP_EN] = lamp_en_r;
			SLI_OFS_STATE: rd_nxt[5:0] = {lamps, light_channel_two, light_channel_one};
			SLI_OFS_IRQ_STAT: rd_nxt[SLI_EV_W-1:0] = irq_stat_r;
			SLI_OFS_IRQ_EN: rd_nxt[SLI_EV_W-1:0] = irq_en_r;
			default: rd_nxt = 32'h0;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_r <= 1'b0;
			avs_readdata <= 32'h0;
		end else if (clk_en) begin
			ack_r <= (avs_read || avs_write) && !ack_r;
			if (rd_go) begin
				avs_readdata <= rd_nxt;
			end
		end
	end

	// Writable control; only the low byte lane holds bits
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lamp_en_r <= SLI_CTRL_RST;
			irq_en_r <= SLI_IRQ_EN_RST;
		end else if (clk_en && wr_go && avs_byteenable[0]) begin
			if (avs_address == SLI_OFS_CTRL) begin
				lamp_en_r <= avs_writedata[SLI_CTRL_LAMP_EN];
			end
			if (avs_address == SLI_OFS_IRQ_EN) begin
				irq_en_r <= avs_writedata[SLI_EV_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_int_fault_red: assert property (clk_en && lamp_en_r && status.internal_fault
		|=> lamps.red1 == $past(fast_on_r) && !lamps.green1)
		else $error("internal fault not shown as fast red");

	a_ext_fault_red: assert property (clk_en && lamp_en_r && !status.internal_fault
		&& status.external_fault |=> lamps.red1 == $past(slow_on) && !lamps.green1)
		else $error("external fault not shown as slow red");

	a_off_steady_red: assert property (clk_en && lamp_en_r && !status.internal_fault
		&& !status.external_fault && !status.outputs_on |=> lamps.red1 && !lamps.green1)
		else $error("outputs off not steady red");

	a_on_green_weak: assert property (clk_en && lamp_en_r && !status.internal_fault
		&& !status.external_fault && status.outputs_on |=> !lamps.red1
		&& lamps.green1 == ($past(status.weak_signal) ? $past(slow_on) : 1'b1))
		else $error("outputs on not green");

	a_yellow_dark: assert property (clk_en && lamp_en_r && burst_st_r == SLI_IDLE
		&& !status.upstream_open && !ready_to_release |=> !lamps.yellow2)
		else $error("lamp two lit without cause");

	a_yellow_steady: assert property (clk_en && lamp_en_r && burst_st_r == SLI_IDLE
		&& !status.upstream_open && ready_to_release && !status.upstream_change |=> lamps.yellow2)
		else $error("release ready not steady yellow");

	a_up_open_flash: assert property (clk_en && lamp_en_r && burst_st_r == SLI_IDLE
		&& status.upstream_open && !status.upstream_change |=> lamps.yellow2 == $past(slow_on))
		else $error("open upstream circuit not flashing");

	a_burst_length: assert property (clk_en && status.upstream_change
		|=> burst_st_r == SLI_BURST && burst_left_r == ($past(status.upstream_twice) ? 3'h4 : 3'h2))
		else $error("burst not loaded with flash count");

	a_blue_dark: assert property (clk_en && !status.teach_failed && !status.teach_required
		&& !status.muting_restart && !status.muting_override && !status.muting_active
		&& !status.blank_taught |=> !lamps.blue3)
		else $error("lamp three lit without special function");

	a_blue_muting: assert property (clk_en && lamp_en_r && !status.teach_failed && !status.teach_required
		&& !status.muting_restart && !status.muting_override && status.muting_active
		|=> lamps.blue3 == $past(slow_on))
		else $error("muting not slow blue");

	a_blue_short: assert property (clk_en && lamp_en_r && !status.teach_failed
		&& status.teach_required |=> lamps.blue3 == ($past(slow_ph_r) == 5'h0))
		else $error("teach required not short blue");

	a_blue_fail: assert property (clk_en && lamp_en_r && status.teach_failed
		|=> lamps.blue3 == $past(fast_on_r))
		else $error("teach failure not fast blue");

	a_channel_excl: assert property (!(light_channel_one && light_channel_two))
		else $error("both channels selected");

	a_tick_period: assert property (clk_en && tick |=> base_cnt_r == 24'h0)
		else $error("divider did not wrap");

endmodule

// ---- shared/sli_pkg.sv ----
// Package of the status lamp indicator: register map, reset values,
// flash timing and the structs that carry status and lamp states.
// Assumes a 40 MHz system clock and a 32-bit Avalon-MM register bus.
package sli_pkg;

	// Register byte offsets
	localparam logic [4:0] SLI_OFS_CTRL = 5'h00;
	localparam logic [4:0] SLI_OFS_STATE = 5'h04;
	localparam logic [4:0] SLI_OFS_IRQ_STAT = 5'h08;
	localparam logic [4:0] SLI_OFS_IRQ_CLR = 5'h0c;
	localparam logic [4:0] SLI_OFS_IRQ_EN = 5'h10;

	// Field positions
	localparam int SLI_CTRL_LAMP_EN = 0;
	localparam int SLI_EV_INT_FAULT = 0;
	localparam int SLI_EV_EXT_FAULT = 1;
	localparam int SLI_EV_UP_CHANGE = 2;
	localparam int SLI_EV_TEACH_FAIL = 3;
	localparam int SLI_EV_CHANNEL = 4;
	localparam int SLI_EV_W = 5;

	// Reset values
	localparam logic SLI_CTRL_RST = 1'b1;
	localparam logic [4:0] SLI_IRQ_EN_RST = 5'h00;

	// Flash timing: one base tick is half a 10 Hz period
	localparam int SLI_CLK_HZ = 40_000_000;
	localparam int SLI_FAST_HALF_MS = 50;
	localparam logic [23:0] SLI_FAST_HALF_CYC = 24'(SLI_CLK_HZ / 1000 * SLI_FAST_HALF_MS);
	localparam logic [4:0] SLI_SLOW_TICKS = 5'd20;
	localparam logic [4:0] SLI_SLOW_ON_TICKS = 5'd10;

	// Receiver state seen by the lamp logic
	typedef struct packed {
		logic outputs_on;
		logic weak_signal;
		logic internal_fault;
		logic external_fault;
		logic interlock_enabled;
		logic interlock_blocking;
		logic field_clear;
		logic linked_ok;
		logic upstream_open;
		logic upstream_change;
		logic upstream_twice;
		logic blank_taught;
		logic muting_active;
		logic teach_required;
		logic muting_restart;
		logic muting_override;
		logic teach_failed;
	} sli_status_s;

	// Lamp drive
	typedef struct packed {
		logic red1;
		logic green1;
		logic yellow2;
		logic blue3;
	} sli_lamps_s;

	typedef enum logic {SLI_IDLE, SLI_BURST} sli_burst_e;

endpackage
